// [core/cie_map.svh]
`ifndef CIE_MAP_SVH
`define CIE_MAP_SVH
// Purpose: bit positions, offsets and reset values of the interrupt gate
// Assumes: 8-bit control registers, 32-bit Wishbone on the command side
// Notes: definitions only

// ==========================================================
// Control register bits
`define CIE_B_GLOBAL_EN 7
`define CIE_B_PERIPH_EN 6
`define CIE_B_T0_EN 5
`define CIE_B_EXT_EN 4
`define CIE_B_PB_EN 3
`define CIE_B_T0_FLAG 2
`define CIE_B_EXT_FLAG 1
`define CIE_B_PB_FLAG 0
`define CIE_CTL_RST 8'h00

// ==========================================================
// Peripheral enable bank one bits
`define CIE_B_CONV 6
`define CIE_B_SRX 5
`define CIE_B_STX 4
`define CIE_B_SYNC 3
`define CIE_B_CAPCMP 2
`define CIE_B_T2_MATCH 1
`define CIE_B_T1_OVF 0
`define CIE_PIE_W 7
`define CIE_PIE_RST 7'h00

// ==========================================================
// Register select on the core link
`define CIE_SEL_CTL 1'b0
`define CIE_SEL_PIE 1'b1
`define CIE_PB_W 8

// ==========================================================
// Command-side register offsets and fields
`define CIE_OFS_CMD 8'h00
`define CIE_OFS_STAT 8'h04
`define CIE_OFS_EVT 8'h08
`define CIE_OFS_MASK 8'h0c
`define CIE_CMD_SEL 0
`define CIE_CMD_WR 1
`define CIE_CMD_DAT_LSB 8
`define CIE_EV_DONE 0
`define CIE_EV_IRQ 1
`define CIE_EV_W 2
`define CIE_EV_RST 2'h0
`define CIE_CMD_RST 32'h0000_0000
`endif

// [core/cie_pkg.sv]
// Purpose: state types for both ends of the interrupt gate
// Assumes: cie_map.svh supplies the widths
// Notes: none
`include "cie_map.svh"
package cie_pkg;
    typedef struct packed {
        logic [7:0] ctl;
        logic [`CIE_PIE_W-1:0] pie;
        logic [`CIE_PB_W-1:0] pb_prev;
        logic ext_prev;
        logic primed;
        logic [7:0] rdata;
        logic ack;
        logic irq;
    } cie_dev_state_t;

    typedef enum logic {CIE_IDLE = 1'b0, CIE_WAIT = 1'b1} cie_host_st_t;

    typedef struct packed {
        cie_host_st_t st;
        logic [31:0] cmd;
        logic [7:0] rd_data;
        logic [`CIE_EV_W-1:0] ev;
        logic [`CIE_EV_W-1:0] mask;
        logic irq_prev;
        logic rd_stb;
        logic wr_stb;
        logic wb_ack;
        logic [31:0] wb_dat;
        logic irq_out;
    } cie_host_state_t;
endpackage

// [core/cie_if.sv]
// Purpose: register link between the core and the interrupt gate
// Assumes: both ends share clk_sys_i
// Notes: strobes are one-cycle pulses
`timescale 1ns/1ps
interface cie_if;
    logic reg_sel;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic reg_ack;
    logic core_irq;

    modport dev (
        input reg_sel,
        input reg_wr,
        input reg_rd,
        input reg_wdata,
        output reg_rdata,
        output reg_ack,
        output core_irq
    );
    modport core (
        output reg_sel,
        output reg_wr,
        output reg_rd,
        output reg_wdata,
        input reg_rdata,
        input reg_ack,
        input core_irq
    );
endinterface

// [core/cie_gate.sv]
// Purpose: interrupt enables, core flags and request gating
// Assumes: event inputs synchronous to clk_sys_i; peripheral flags held outside
// Notes: one access per strobe, answered one cycle later
//   port-B flag sets only for pins whose change enable is set
//   port-B flag clears on reset although the part leaves it unknown
//   peripheral flags are levels held by their own blocks
//
// How it works
// - Global enable gates every interrupt request
// - Peripheral enable gates all peripheral interrupts
// - Timer-0 overflow passes only when enabled
// - External pin interrupt passes only when enabled
// - Port-B change needs group and pin enable
// - Rollover sets timer-0 flag until software clears
// - External event sets flag until software clears
// - A change on any port-B pin whose change enable is set sets change flag
// - Software initialises timer-0 count before clearing
// - Bank-one sources also need peripheral enable
// - Converter interrupt passes only when enabled
// - Sync port interrupt passes only when enabled
// - Capture/compare one passes only when enabled
// - Timer-two match passes only when enabled
// - Timer-one overflow enabled; bank resets to zero
// - Flags set regardless of the interrupt enable bits
// - Edge select picks rising or falling edge
`timescale 1ns/1ps
`include "cie_map.svh"
module cie_gate (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    cie_if.dev bus,
    input wire logic timer_zero_count_roll_i,
    input wire logic ext_pin_i,
    input wire logic ext_edge_select_i,
    input wire logic [`CIE_PB_W-1:0] port_b_a_i,
    input wire logic [`CIE_PB_W-1:0] per_pin_change_enable_i,
    input wire logic [`CIE_PIE_W-1:0] periph_flag_i
);
    cie_pkg::cie_dev_state_t q;
    cie_pkg::cie_dev_state_t d;
    logic ext_hit;
    logic pb_hit;
    logic t0_pend;
    logic ext_pend;
    logic pb_pend;
    logic core_pend;
    logic per_gate;
    logic [`CIE_PIE_W-1:0] per_pend;

    // ==========================================================
    // Helpers
    // Enable and flag pair; the same gate serves every source
    function automatic logic pair_hit(
        input logic en,
        input logic flg
    );
        return en & flg;
    endfunction

    // Selected edge of a level seen against its last sample
    function automatic logic edge_seen(
        input logic now,
        input logic prev,
        input logic rising
    );
        logic r;
        if (rising)
            r = now & ~prev;
        else
            r = ~now & prev;
        return r;
    endfunction

    // Any change on a pin whose change enable is set
    function automatic logic change_seen(
        input logic [`CIE_PB_W-1:0] now,
        input logic [`CIE_PB_W-1:0] prev,
        input logic [`CIE_PB_W-1:0] en
    );
        return |((now ^ prev) & en);
    endfunction

    // Unimplemented top bit of the enable bank reads zero
    function automatic logic [7:0] read_back(
        input logic sel,
        input logic [7:0] ctl,
        input logic [`CIE_PIE_W-1:0] pie
    );
        logic [7:0] r;
        if (sel == `CIE_SEL_CTL)
            r = ctl;
        else
            r = {1'b0, pie};
        return r;
    endfunction

    // ==========================================================
    // Next state
    always_comb
    begin
        d = q;
        d.ack = 1'b0;
        ext_hit = 1'b0;
        pb_hit = 1'b0;
        t0_pend = 1'b0;
        ext_pend = 1'b0;
        pb_pend = 1'b0;
        core_pend = 1'b0;
        per_gate = 1'b0;
        per_pend = '0;

        // ==========================================================
        // Software access
        // A write wins over a read strobe in the same cycle
        if (bus.reg_wr)
        begin
            d.ack = 1'b1;
            if (bus.reg_sel == `CIE_SEL_CTL)
            begin
                d.ctl = bus.reg_wdata;
            end
            else
            begin
                d.pie = bus.reg_wdata[`CIE_PIE_W-1:0];
            end
        end
        else if (bus.reg_rd)
        begin
            d.ack = 1'b1;
            // Shows the value before any hardware set in the same cycle
            d.rdata = read_back(bus.reg_sel, q.ctl, q.pie);
        end

        // ==========================================================
        // Hardware flag sets
        // They come after the software write so a set is never lost
        if (timer_zero_count_roll_i)
            d.ctl[`CIE_B_T0_FLAG] = 1'b1;

        if (q.primed)
        begin
            ext_hit = edge_seen(ext_pin_i, q.ext_prev, ext_edge_select_i);
            pb_hit = change_seen(port_b_a_i, q.pb_prev, per_pin_change_enable_i);
        end
        if (ext_hit)
            d.ctl[`CIE_B_EXT_FLAG] = 1'b1;
        if (pb_hit)
            d.ctl[`CIE_B_PB_FLAG] = 1'b1;

        // Inputs sampled once before edges count, so reset does not fake a change
        d.ext_prev = ext_pin_i;
        d.pb_prev = port_b_a_i;
        d.primed = 1'b1;

        // ==========================================================
        // Request gating
        t0_pend = pair_hit(d.ctl[`CIE_B_T0_EN], d.ctl[`CIE_B_T0_FLAG]);
        ext_pend = pair_hit(d.ctl[`CIE_B_EXT_EN], d.ctl[`CIE_B_EXT_FLAG]);
        pb_pend = pair_hit(d.ctl[`CIE_B_PB_EN], d.ctl[`CIE_B_PB_FLAG]);
        core_pend = t0_pend | ext_pend | pb_pend;

        per_pend[`CIE_B_CONV] = pair_hit(d.pie[`CIE_B_CONV],
            periph_flag_i[`CIE_B_CONV]);
        per_pend[`CIE_B_SRX] = pair_hit(d.pie[`CIE_B_SRX],
            periph_flag_i[`CIE_B_SRX]);
        per_pend[`CIE_B_STX] = pair_hit(d.pie[`CIE_B_STX],
            periph_flag_i[`CIE_B_STX]);
        per_pend[`CIE_B_SYNC] = pair_hit(d.pie[`CIE_B_SYNC],
            periph_flag_i[`CIE_B_SYNC]);
        per_pend[`CIE_B_CAPCMP] = pair_hit(d.pie[`CIE_B_CAPCMP],
            periph_flag_i[`CIE_B_CAPCMP]);
        per_pend[`CIE_B_T2_MATCH] = pair_hit(d.pie[`CIE_B_T2_MATCH],
            periph_flag_i[`CIE_B_T2_MATCH]);
        per_pend[`CIE_B_T1_OVF] = pair_hit(d.pie[`CIE_B_T1_OVF],
            periph_flag_i[`CIE_B_T1_OVF]);

        // Peripheral sources count only behind the group enable
        per_gate = d.ctl[`CIE_B_PERIPH_EN] & (|per_pend);

        // Request is registered from the next enables and flags; it moves with the stored enables and one cycle after periph_flag_i
        d.irq = d.ctl[`CIE_B_GLOBAL_EN]
            & (core_pend | per_gate);
    end

    // ==========================================================
    // State register
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            q.ctl <= `CIE_CTL_RST;
            q.pie <= `CIE_PIE_RST;
            q.pb_prev <= '0;
            q.ext_prev <= 1'b0;
            q.primed <= 1'b0;
            q.rdata <= 8'h00;
            q.ack <= 1'b0;
            q.irq <= 1'b0;
        end
        else
        begin
            q <= d;
        end
    end

    assign bus.reg_rdata = q.rdata;
    assign bus.reg_ack = q.ack;
    assign bus.core_irq = q.irq;
endmodule

// [core/cie_core_port.sv]
// Purpose: core-side end; Wishbone command registers drive the link
// Assumes: classic Wishbone, 32-bit data, byte addresses
// Notes: a new command is ignored while one is in flight
`timescale 1ns/1ps
`include "cie_map.svh"
module cie_core_port (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    cie_if.core bus,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic int_o
);
    cie_pkg::cie_host_state_t q;
    cie_pkg::cie_host_state_t d;
    logic hit;
    logic go;
    logic done;
    logic clr_ev;
    logic [31:0] mask_new;

    function automatic logic [31:0] merge32(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0] sel
    );
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++)
            if (sel[i])
                r[8*i +: 8] = new_v[8*i +: 8];
        return r;
    endfunction

    // ==========================================================
    // Next state
    always_comb
    begin
        d = q;
        d.wb_ack = 1'b0;
        d.rd_stb = 1'b0;
        d.wr_stb = 1'b0;
        hit = wb_cyc_i & wb_stb_i & ~q.wb_ack;
        go = 1'b0;
        done = 1'b0;
        clr_ev = 1'b0;
        mask_new = '0;

        if (hit)
        begin
            d.wb_ack = 1'b1;
            d.wb_dat = 32'h0000_0000;
            case (wb_adr_i)
                `CIE_OFS_CMD:
                begin
                    d.wb_dat = q.cmd;
                    if (wb_we_i && q.st == cie_pkg::CIE_IDLE)
                    begin
                        d.cmd = merge32(q.cmd, wb_dat_i, wb_sel_i);
                        go = wb_sel_i[0];
                    end
                end
                `CIE_OFS_STAT:
                    d.wb_dat = {15'h0000, bus.core_irq, q.rd_data, 7'h00,
                        q.st == cie_pkg::CIE_WAIT};
                `CIE_OFS_EVT:
                begin
                    d.wb_dat = {30'h0000_0000, q.ev};
                    clr_ev = ~wb_we_i;
                end
                `CIE_OFS_MASK:
                begin
                    d.wb_dat = {30'h0000_0000, q.mask};
                    if (wb_we_i)
                    begin
                        mask_new = merge32({30'h0000_0000, q.mask}, wb_dat_i, wb_sel_i);
                        d.mask = mask_new[`CIE_EV_W-1:0];
                    end
                end
                default:
                    d.wb_dat = 32'h0000_0000;
            endcase
        end

        unique case (q.st)
            cie_pkg::CIE_IDLE:
                if (go)
                begin
                    d.wr_stb = d.cmd[`CIE_CMD_WR];
                    d.rd_stb = ~d.cmd[`CIE_CMD_WR];
                    d.st = cie_pkg::CIE_WAIT;
                end
            cie_pkg::CIE_WAIT:
                if (bus.reg_ack)
                begin
                    if (!q.cmd[`CIE_CMD_WR])
                        d.rd_data = bus.reg_rdata;
                    done = 1'b1;
                    d.st = cie_pkg::CIE_IDLE;
                end
        endcase

        // Read clears, but an event in the same cycle survives
        d.irq_prev = bus.core_irq;
        d.ev = clr_ev ? `CIE_EV_RST : q.ev;
        d.ev[`CIE_EV_DONE] = d.ev[`CIE_EV_DONE] | done;
        d.ev[`CIE_EV_IRQ] = d.ev[`CIE_EV_IRQ] | (bus.core_irq & ~q.irq_prev);
        d.irq_out = |(d.ev & d.mask);
    end

    // ==========================================================
    // State register
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            q.st <= cie_pkg::CIE_IDLE;
            q.cmd <= `CIE_CMD_RST;
            q.rd_data <= 8'h00;
            q.ev <= `CIE_EV_RST;
            q.mask <= `CIE_EV_RST;
            q.irq_prev <= 1'b0;
            q.rd_stb <= 1'b0;
            q.wr_stb <= 1'b0;
            q.wb_ack <= 1'b0;
            q.wb_dat <= 32'h0000_0000;
            q.irq_out <= 1'b0;
        end
        else
        begin
            q <= d;
        end
    end

    assign bus.reg_sel = q.cmd[`CIE_CMD_SEL];
    assign bus.reg_wdata = q.cmd[`CIE_CMD_DAT_LSB +: 8];
    assign bus.reg_wr = q.wr_stb;
    assign bus.reg_rd = q.rd_stb;
    assign wb_dat_o = q.wb_dat;
    assign wb_ack_o = q.wb_ack;
    assign int_o = q.irq_out;
endmodule

// [tb/cie_props.sv]
// Purpose: link handshake and request gating properties
// Assumes: one clock domain, reset active low
// Notes: shadows the written enables to judge the request line
`timescale 1ns/1ps
module cie_props (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic reg_sel,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_ack,
    input wire logic core_irq
);
    // ====================
    // Shadow of written enables
    logic [4:0] en_q;
    logic [6:0] pie_q;
    always_ff @(posedge clk_sys_i or negedge nrst_i)
        if (!nrst_i)
        begin
            en_q <= 5'h00;
            pie_q <= 7'h00;
        end
        else if (reg_wr && !reg_sel)
            en_q <= reg_wdata[7:3];
        else if (reg_wr)
            pie_q <= reg_wdata[6:0];

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!nrst_i);

    // ====================
    // Sequences and properties
    sequence s_rd_ctl;
        reg_rd && !reg_wr && !reg_sel ##1 reg_ack;
    endsequence
    sequence s_rd_pie;
        reg_rd && !reg_wr && reg_sel ##1 reg_ack;
    endsequence
    property p_ack;
        (reg_wr || reg_rd) |=> reg_ack;
    endproperty
    property p_ack_cause;
        reg_ack |-> $past(reg_wr || reg_rd);
    endproperty
    property p_rdata_hold;
        $changed(reg_rdata) |-> reg_ack && $past(reg_rd && !reg_wr);
    endproperty
    property p_gie_off;
        !en_q[4] |-> !core_irq;
    endproperty
    property p_no_src;
        en_q[3:0] == 4'h0 |-> !core_irq;
    endproperty
    property p_irq_on;
        reg_wr && !reg_sel && reg_wdata[7] && reg_wdata[5] && reg_wdata[2] |=> core_irq;
    endproperty
    property p_ctl_rd;
        s_rd_ctl |-> reg_rdata[7:3] == en_q;
    endproperty
    property p_pie_rd;
        s_rd_pie |-> reg_rdata == {1'b0, pie_q};
    endproperty

    a_ack: assert property (p_ack) else $error("no link answer");
    a_ack_cause: assert property (p_ack_cause) else $error("answer without strobe");
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
    a_gie_off: assert property (p_gie_off) else $error("request with global off");
    a_no_src: assert property (p_no_src) else $error("request with no source");
    a_irq_on: assert property (p_irq_on) else $error("timer request missing");
    a_ctl_rd: assert property (p_ctl_rd) else $error("control enables readback");
    a_pie_rd: assert property (p_pie_rd) else $error("bank one readback");
endmodule

// [tb/core_interrupt_enable_flags_test.sv]
// Purpose: both ends of the interrupt gate driven over Wishbone
// Assumes: command layout and offsets of cie_map.svh
// Notes: random control, enable and peripheral levels plus corner cases
`timescale 1ns/1ps
`include "cie_map.svh"
module core_interrupt_enable_flags_test;
    logic clk_sys_i = 1'b0;
    logic nrst_i = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0000_0000;
    logic [31:0] rdat, q;
    logic ack, int_o;
    logic roll = 1'b0;
    logic pin = 1'b0;
    logic esel = 1'b0;
    logic [7:0] pb = 8'h00;
    logic [7:0] ppce = 8'h00;
    logic [6:0] pf = 7'h00;
    logic [7:0] r, c;
    logic [6:0] p;
    integer seed = 32'hac05;
    integer mismatches = 0;
    integer checks = 0;
    integer i;

    always #5 clk_sys_i = ~clk_sys_i;

    cie_if cie_if_i ();
    cie_gate cie_gate_i (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .bus(cie_if_i),
        .timer_zero_count_roll_i(roll), .ext_pin_i(pin), .ext_edge_select_i(esel), .port_b_a_i(pb),
        .per_pin_change_enable_i(ppce), .periph_flag_i(pf));
    cie_core_port cie_core_port_i (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .bus(cie_if_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat),
        .wb_sel_i(4'hf), .wb_dat_o(rdat), .wb_ack_o(ack), .int_o(int_o));
    cie_props cie_props_i (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
        .reg_sel(cie_if_i.reg_sel), .reg_wr(cie_if_i.reg_wr), .reg_rd(cie_if_i.reg_rd),
        .reg_wdata(cie_if_i.reg_wdata), .reg_rdata(cie_if_i.reg_rdata),
        .reg_ack(cie_if_i.reg_ack), .core_irq(cie_if_i.core_irq));

    // ====================
    // Checks and bus tasks
    task chk8(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("mismatch at %0t: got %h want %h", $time, g, e);
        end
    endtask

    task chk1(input logic g, input logic e);
        checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("mismatch at %0t: bit %b want %b", $time, g, e);
        end
    endtask

    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do @(posedge clk_sys_i); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    // Polls busy so the link answer has landed before read data is used
    task dev(input logic w, input logic s, input logic [7:0] v);
        wb(1'b1, `CIE_OFS_CMD, {16'h0000, v, 6'h00, w, s});
        do wb(1'b0, `CIE_OFS_STAT, 32'h0); while (q[0] !== 1'b0);
        r = q[15:8];
    endtask

    function logic exp_irq(input logic [7:0] k, input logic [6:0] e, input logic [6:0] f);
        return k[7] & ((k[5] & k[2]) | (k[4] & k[1]) | (k[3] & k[0]) | (k[6] & |(e & f)));
    endfunction

    task wrap_up;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial
    begin
        #400000;
        mismatches++;
        wrap_up;
    end

    // ====================
    // Test sequence
    initial
    begin
        repeat (16) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        dev(1'b0, 1'b0, 8'h00);
        chk8(r, `CIE_CTL_RST);
        dev(1'b0, 1'b1, 8'h00);
        chk8(r, 8'h00);
        wb(1'b0, 8'h10, 32'h0);
        chk8(q[7:0], 8'h00);
        $display("test reset done");
        for (i = 0; i < 40; i++)
        begin
            c = (i == 0) ? 8'h7f : (i == 1) ? 8'hff : 8'($random(seed));
            p = 7'($random(seed));
            pf <= 7'($random(seed));
            dev(1'b1, 1'b1, {1'b1, p});
            dev(1'b1, 1'b0, c);
            dev(1'b0, 1'b0, 8'h00);
            chk8(r, c);
            dev(1'b0, 1'b1, 8'h00);
            chk8(r, {1'b0, p});
            wb(1'b0, `CIE_OFS_STAT, 32'h0);
            chk1(q[16], exp_irq(c, p, pf));
        end
        $display("test gating done");
        dev(1'b1, 1'b0, 8'h00);
        @(posedge clk_sys_i);
        roll <= 1'b1;
        @(posedge clk_sys_i);
        roll <= 1'b0;
        dev(1'b0, 1'b0, 8'h00);
        chk8(r, 8'h04);
        dev(1'b1, 1'b0, 8'h00);
        dev(1'b0, 1'b0, 8'h00);
        chk8(r, 8'h00);
        for (i = 0; i < 2; i++)
        begin
            esel <= i[0];
            pin <= i[0];
            dev(1'b1, 1'b0, 8'h00);
            pin <= !i[0];
            dev(1'b0, 1'b0, 8'h00);
            chk8(r, 8'h00);
            pin <= i[0];
            dev(1'b0, 1'b0, 8'h00);
            chk8(r, 8'h02);
        end
        $display("test flags done");
        for (i = 0; i < 4; i++)
        begin
            c = 8'h01 << ($random(seed) & 7);
            ppce <= c;
            dev(1'b1, 1'b0, 8'h00);
            pb <= pb ^ ~c;
            dev(1'b0, 1'b0, 8'h00);
            chk8(r, 8'h00);
            pb <= pb ^ c;
            dev(1'b0, 1'b0, 8'h00);
            chk8(r, 8'h01);
        end
        $display("test port change done");
        // Mask on, then off: status must latch either way
        for (i = 0; i < 2; i++)
        begin
            wb(1'b1, `CIE_OFS_MASK, i ? 32'h0 : 32'h2);
            dev(1'b1, 1'b0, 8'h00);
            wb(1'b0, `CIE_OFS_EVT, 32'h0);
            dev(1'b1, 1'b0, 8'ha4);
            chk1(int_o, !i[0]);
            wb(1'b0, `CIE_OFS_EVT, 32'h0);
            chk1(q[1], 1'b1);
            repeat (2) @(posedge clk_sys_i);
            chk1(int_o, 1'b0);
        end
        $display("test interrupt done");
        wrap_up;
    end
endmodule
